//--- rtl/flash_lat_map.svh
// Named constants for the read dummy-latency block.
// Assumes inclusion by bare name from the design files only.
`ifndef FLASH_LAT_MAP_SVH
`define FLASH_LAT_MAP_SVH

// ---------------------------------------------------------------
// Read parameter register layout
// ---------------------------------------------------------------
`define RD_PARAM_RESET      8'h00
`define DUMMY_FIELD_MSB     6
`define DUMMY_FIELD_LSB     3
`define DUMMY_USE_DEFAULT   4'h0

// ---------------------------------------------------------------
// Read opcodes
// ---------------------------------------------------------------
`define OP_FAST_READ        8'h0b
`define OP_FAST_READ_4B     8'h0c
`define OP_FAST_READ_DR     8'h0d
`define OP_FAST_READ_DR_4B  8'h0e
`define OP_DUAL_OUT         8'h3b
`define OP_DUAL_OUT_4B      8'h3c
`define OP_DUAL_IO          8'hbb
`define OP_DUAL_IO_4B       8'hbc
`define OP_DUAL_IO_DR       8'hbd
`define OP_DUAL_IO_DR_4B    8'hbe
`define OP_QUAD_OUT         8'h6b
`define OP_QUAD_OUT_4B      8'h6c
`define OP_QUAD_IO          8'heb
`define OP_QUAD_IO_4B       8'hec
`define OP_QUAD_IO_DR       8'hed
`define OP_QUAD_IO_DR_4B    8'hee

// ---------------------------------------------------------------
// Default dummy clock counts
// ---------------------------------------------------------------
`define LAT_NONE            4'h0
`define LAT_FAST_SERIAL     4'h8
`define LAT_FAST_QUAD_CMD   4'h6
`define LAT_DUAL_OUT        4'h8
`define LAT_DUAL_IO         4'h4
`define LAT_QUAD_OUT        4'h8
`define LAT_QUAD_IO         4'h6

`endif

//--- rtl/flash_lat_pkg.sv
// Types shared by the read dummy-latency design.
// Assumes the constants header is included where numbers are needed.
package flash_lat_pkg;

  // -------------------------------------------------------------
  // Controller states
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA
  } lat_state_t;

endpackage

//--- rtl/dummy_if.sv
// Carrier between the latency controller and the dummy counter.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
interface dummy_if #(parameter int CW = 4);
  logic          load;
  logic [CW-1:0] count;
  logic          tick;
  logic          done;
  logic          busy;

  modport ctrl (output load, output count, output tick,
                input done, input busy);
  modport cnt  (input load, input count, input tick,
                output done, output busy);
endinterface

//--- rtl/dummy_counter.sv
// Dummy clock counter: loaded with a count, decremented per tick.
// Assumes ticks are one-cycle pulses in the core clock domain.
`timescale 1ns/10ps
module dummy_counter
  #(parameter int CW = 4)
  (input  wire logic core_clk,
   input  wire logic srst,
   dummy_if.cnt      dif);

  logic [CW-1:0] remain_reg;
  logic          busy_reg;
  logic          done_reg;

  // ---------------------------------------------------------------
  // Counting
  // ---------------------------------------------------------------
  // Load wins over a tick in the same cycle; a new read restarts
  always_ff @(posedge core_clk) begin
    if (srst) begin
      remain_reg <= '0;
      busy_reg   <= 1'b0;
    end else if (dif.load) begin
      remain_reg <= dif.count;
      busy_reg   <= (dif.count != '0);
    end else if (busy_reg && dif.tick) begin
      remain_reg <= remain_reg - 1'b1; // R13
      busy_reg   <= (remain_reg != 1'b1);
    end
  end

  // Done pulse one cycle after the tick that takes the last dummy clock
  always_ff @(posedge core_clk) begin
    if (srst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= !dif.load && busy_reg && dif.tick &&
                  (remain_reg == 1'b1); // R13
    end
  end

  assign dif.busy = busy_reg;
  assign dif.done = done_reg;
endmodule

//--- rtl/flash_read_latency.sv
// Read dummy-latency control of a serial flash device.
// Assumes the opcode and address-end strobes come from core-clock
// logic, while the serial clock and chip enable are raw pins.
//
// Overview of operation
// R1 - zero picks default, else exact dummy count
// R2 - fast read: 8 serial, 6 quad-command
// R3 - dual-output read defaults to 8 clocks
// R4 - dual-IO reads default to 4 clocks
// R5 - quad-output read defaults to 8 clocks
// R6 - quad-IO reads default to 6 clocks
// R7 - identifier and info-row reads follow fast read
// R8 - dual-IO double-rate read refused in quad-command
// R9 - host picks dummy count fit for clock
// R10 - host floats trailing mode half on overlap
// R11 - host caps clock by dummy count, command
// R12 - field at bits 6:3, reset zero, power-up load
// R13 - count rising edges, then drive data
`timescale 1ns/10ps
`include "flash_lat_map.svh"
module flash_read_latency
  import flash_lat_pkg::*;
  #(parameter logic [7:0] UID_OPCODE = 8'hf1, // Arbitrary value
    parameter logic [7:0] IRR_OPCODE = 8'hf2, // Arbitrary value
    parameter int         CW         = 4)
  (input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        sck,
   input  wire logic        ce_n,
   input  wire logic        quad_command_mode,
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_opcode,
   input  wire logic        addr_done,
   input  wire logic        nv_load,
   input  wire logic [7:0]  nv_read_param,
   input  wire logic        param_wr,
   input  wire logic [7:0]  param_wr_data,
   output logic [7:0]       read_param_reg,
   output logic [CW-1:0]    latency_reg,
   output logic             cmd_reject_reg,
   output logic             dummy_phase,
   output logic             data_start,
   output logic             data_phase);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] sck_sync_reg;
  logic [1:0] ce_sync_reg;
  logic       sck_prev_reg;
  logic       sck_rise;
  logic       ce_n_s;

  // Two stages each; only stage two feeds logic
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sck_sync_reg <= 2'h0;
      ce_sync_reg  <= 2'h3;
      sck_prev_reg <= 1'b0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[0], sck};
      ce_sync_reg  <= {ce_sync_reg[0], ce_n};
      sck_prev_reg <= sck_sync_reg[1];
    end
  end

  assign sck_rise = sck_sync_reg[1] && !sck_prev_reg;
  assign ce_n_s   = ce_sync_reg[1];

  // ---------------------------------------------------------------
  // Per-command default latency
  // ---------------------------------------------------------------
  // Returns zero for opcodes that carry no dummy phase
  function automatic logic [3:0] default_latency(
    input logic [7:0] op,
    input logic       quad);
    logic [3:0] lat;
    lat = `LAT_NONE;
    if (op == UID_OPCODE || op == IRR_OPCODE) begin
      lat = quad ? `LAT_FAST_QUAD_CMD : `LAT_FAST_SERIAL; // R7
    end else begin
      case (op)
        `OP_FAST_READ, `OP_FAST_READ_4B,
        `OP_FAST_READ_DR, `OP_FAST_READ_DR_4B: begin
          lat = quad ? `LAT_FAST_QUAD_CMD : `LAT_FAST_SERIAL; // R2
        end
        `OP_DUAL_OUT, `OP_DUAL_OUT_4B: begin
          lat = `LAT_DUAL_OUT; // R3
        end
        `OP_DUAL_IO, `OP_DUAL_IO_4B,
        `OP_DUAL_IO_DR, `OP_DUAL_IO_DR_4B: begin
          lat = `LAT_DUAL_IO; // R4
        end
        `OP_QUAD_OUT, `OP_QUAD_OUT_4B: begin
          lat = `LAT_QUAD_OUT; // R5
        end
        `OP_QUAD_IO, `OP_QUAD_IO_4B,
        `OP_QUAD_IO_DR, `OP_QUAD_IO_DR_4B: begin
          lat = `LAT_QUAD_IO; // R6
        end
        default: begin
          lat = `LAT_NONE;
        end
      endcase
    end
    return lat;
  endfunction

  // Dual-IO double-rate read has no quad-command form
  function automatic logic refused_in_mode(
    input logic [7:0] op,
    input logic       quad);
    return quad && (op == `OP_DUAL_IO_DR ||
                    op == `OP_DUAL_IO_DR_4B);
  endfunction

  // ---------------------------------------------------------------
  // Volatile read parameter register
  // ---------------------------------------------------------------
  // Software write beats a power-up copy arriving together
  always_ff @(posedge core_clk) begin
    if (srst) begin
      read_param_reg <= `RD_PARAM_RESET; // R12
    end else if (param_wr) begin
      read_param_reg <= param_wr_data;
    end else if (nv_load) begin
      read_param_reg <= nv_read_param; // R12
    end
  end

  logic [3:0]    dummy_field;
  logic [3:0]    cmd_default;
  logic [CW-1:0] latency_next;
  logic          cmd_is_read;
  logic          cmd_refused;

  assign dummy_field = read_param_reg[`DUMMY_FIELD_MSB:`DUMMY_FIELD_LSB];
  assign cmd_default = default_latency(cmd_opcode, quad_command_mode);
  assign cmd_is_read = (cmd_default != `LAT_NONE);
  assign cmd_refused = refused_in_mode(cmd_opcode, quad_command_mode);

  // Explicit field overrides every default when nonzero
  always_comb begin
    if (dummy_field == `DUMMY_USE_DEFAULT) begin
      latency_next = CW'(cmd_default); // R1
    end else begin
      latency_next = CW'(dummy_field); // R1
    end
  end

  // ---------------------------------------------------------------
  // Read sequencing
  // ---------------------------------------------------------------
  lat_state_t state_reg;
  lat_state_t state_next;
  logic       take_cmd;
  logic       start_dummy;

  dummy_if #(.CW(CW)) dif ();

  assign take_cmd    = (state_reg == ST_IDLE) && cmd_valid && !ce_n_s;
  assign start_dummy = (state_reg == ST_ADDR) && addr_done && !ce_n_s;

  // Chip enable high ends any read at once
  always_comb begin
    state_next = state_reg;
    if (ce_n_s) begin
      state_next = ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (take_cmd && cmd_is_read && !cmd_refused) begin
            state_next = ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (addr_done) begin
            state_next = ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          if (dif.done) begin
            state_next = ST_DATA; // R13
          end
        end
        ST_DATA: begin
          state_next = ST_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Latency is frozen per read so a mid-read write cannot skew it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      latency_reg <= '0;
    end else if (take_cmd && cmd_is_read && !cmd_refused) begin
      latency_reg <= latency_next;
    end
  end

  // Refusal pulse; the host must not send it in this mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_reject_reg <= 1'b0;
    end else begin
      cmd_reject_reg <= take_cmd && cmd_refused; // R8
    end
  end

  // ---------------------------------------------------------------
  // Dummy counter hookup
  // ---------------------------------------------------------------
  // Rising edges only count once the address phase has closed
  assign dif.load  = start_dummy;
  assign dif.count = latency_reg;
  assign dif.tick  = (state_reg == ST_DUMMY) && sck_rise; // R13

  dummy_counter #(.CW(CW)) u_dummy_counter (
    .core_clk (core_clk),
    .srst     (srst),
    .dif      (dif)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign dummy_phase = (state_reg == ST_DUMMY);
  assign data_start  = (state_reg == ST_DUMMY) && dif.done; // R13
  assign data_phase  = (state_reg == ST_DATA);
endmodule

//--- testbench/flash_host_model.sv
// Host model: drives chip enable and the serial clock of one frame.
// Assumes the bench moves sel and run between core clock edges.
`timescale 1ns/10ps
module flash_host_model
  (input  wire logic sel,
   input  wire logic run,
   output logic       sck,
   output logic       ce_n);
  // --------
  // Frame and serial clock
  // --------
  // Chip enable simply follows the frame select
  assign ce_n = !sel;
  // No data lines are driven here, so no overlap with the device
  initial sck = 1'b0;
  // 12.5 MHz, far below every cap, so any dummy count is safe
  always begin
    if (run) begin
      #40 sck = 1'b1;
      #40 sck = 1'b0;
    end else begin
      @(run);
    end
  end
endmodule

//--- testbench/flash_read_latency_properties.sv
// Port checker of the read dummy-latency block.
// Assumes it is bound onto flash_read_latency with the same CW.
`timescale 1ns/10ps
module flash_read_latency_properties
  import flash_lat_pkg::*;
  #(parameter int CW = 4)
  (input wire logic          core_clk,
   input wire logic          srst,
   input wire logic          sck,
   input wire logic          ce_n,
   input wire logic          quad_command_mode,
   input wire logic          cmd_valid,
   input wire logic [7:0]    cmd_opcode,
   input wire logic          addr_done,
   input wire logic          nv_load,
   input wire logic [7:0]    nv_read_param,
   input wire logic          param_wr,
   input wire logic [7:0]    param_wr_data,
   input wire logic [7:0]    read_param_reg,
   input wire logic [CW-1:0] latency_reg,
   input wire logic          cmd_reject_reg,
   input wire logic          dummy_phase,
   input wire logic          data_start,
   input wire logic          data_phase);
  // --------
  // Properties
  // --------
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_WR_TAKES: assert property (param_wr |=>
    read_param_reg == $past(param_wr_data)) else $error("write lost");
  AST_NV_LOADS: assert property (nv_load && !param_wr |=>
    read_param_reg == $past(nv_read_param)) else $error("load lost");
  AST_RESET_CLEAR: assert property ($fell(srst) |->
    read_param_reg == 8'h00 && latency_reg == '0) else $error("no clear");
  AST_EXACT_COUNT: assert property ($changed(latency_reg) &&
    $past(read_param_reg[6:3]) != 4'h0 |-> latency_reg ==
    $past(read_param_reg[6:3])) else $error("count not exact");
  AST_DUAL_IO_DEFAULT: assert property ($changed(latency_reg) &&
    $past(read_param_reg[6:3]) == 4'h0 && $past(cmd_opcode) inside
    {8'hbb, 8'hbc, 8'hbd, 8'hbe} |-> latency_reg == 4)
    else $error("dual io default wrong");
  AST_REJECT_CAUSE: assert property (cmd_reject_reg |->
    $past(cmd_valid) && $past(quad_command_mode) &&
    $past(cmd_opcode) inside {8'hbd, 8'hbe}) else $error("bad reject");
  AST_REJECT_PULSE: assert property (cmd_reject_reg |=>
    !cmd_reject_reg && !dummy_phase) else $error("reject too long");
  AST_START_IN_DUMMY: assert property (data_start |->
    dummy_phase && $past(dummy_phase)) else $error("start outside dummy");
  AST_START_THEN_DATA: assert property (data_start |=>
    data_phase && !dummy_phase) else $error("no data after dummy");
  // Main scenarios reached
  cover property (cmd_reject_reg);
  cover property (data_start);
  cover property (param_wr && nv_load);
endmodule
bind flash_read_latency flash_read_latency_properties #(.CW(CW))
  i_flash_read_latency_properties (.core_clk(core_clk), .srst(srst),
  .sck(sck), .ce_n(ce_n), .quad_command_mode(quad_command_mode),
  .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .addr_done(addr_done),
  .nv_load(nv_load), .nv_read_param(nv_read_param), .param_wr(param_wr),
  .param_wr_data(param_wr_data), .read_param_reg(read_param_reg),
  .latency_reg(latency_reg), .cmd_reject_reg(cmd_reject_reg),
  .dummy_phase(dummy_phase), .data_start(data_start),
  .data_phase(data_phase));

//--- testbench/flash_read_latency_test.sv
// Self-checking bench of the read dummy-latency block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/10ps
module flash_read_latency_test;
  logic       core_clk, srst, sck, ce_n, qmode, cmd_valid, addr_done;
  logic       nv_load, param_wr, sel, run, cmd_reject_reg, dummy_phase;
  logic       data_start, data_phase;
  logic [7:0] cmd_opcode, nv_read_param, param_wr_data, read_param_reg;
  logic [3:0] latency_reg;
  int         num_errors = 0, comparisons = 0, nrise = 0;
  // --------
  // Clock, host and design
  // --------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge sck) nrise = nrise + 1;
  flash_host_model i_flash_host_model (.sel(sel), .run(run), .sck(sck),
    .ce_n(ce_n));
  flash_read_latency i_flash_read_latency (.core_clk(core_clk),
    .srst(srst), .sck(sck), .ce_n(ce_n), .quad_command_mode(qmode),
    .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .addr_done(addr_done),
    .nv_load(nv_load), .nv_read_param(nv_read_param), .param_wr(param_wr),
    .param_wr_data(param_wr_data), .read_param_reg(read_param_reg),
    .latency_reg(latency_reg), .cmd_reject_reg(cmd_reject_reg),
    .dummy_phase(dummy_phase), .data_start(data_start),
    .data_phase(data_phase));
  // --------
  // Shared tasks
  // --------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Whole read: command, address end, then count serial rises to data
  task automatic read_op(input logic [7:0] op, input logic q,
                         input logic [7:0] lat_in);
    int i;
    int base;
    qmode = q;
    sel = 1'b1;
    cyc(3);
    cmd_opcode = op;
    cmd_valid = 1'b1;
    cyc(1);
    cmd_valid = 1'b0;
    chk("latency", {4'h0, latency_reg}, lat_in);
    addr_done = 1'b1;
    cyc(1);
    addr_done = 1'b0;
    chk("dummy phase", {7'h0, dummy_phase}, 8'h01);
    base = nrise;
    run = 1'b1;
    for (i = 0; i < 300 && data_start !== 1'b1; i++) cyc(1);
    if (i == 300) begin
      num_errors++;
      end_sim();
    end
    chk("dummy clocks", 8'(nrise - base), lat_in);
    cyc(1);
    chk("data phase", {7'h0, data_phase}, 8'h01);
    run = 1'b0;
    sel = 1'b0;
    cyc(12);
  endtask
  // --------
  // Scenarios
  // --------
  task automatic test_defaults;
    logic [7:0] ops [14] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'hf1, 8'hf2,
      8'h3b, 8'h3c, 8'hbb, 8'hbd, 8'hbe, 8'h6c, 8'heb, 8'hee};
    logic qm [14] = '{0, 1, 0, 1, 0, 1, 0, 0, 0, 0, 0, 0, 1, 0};
    logic [7:0] lat [14] = '{8, 6, 8, 6, 8, 6, 8, 8, 4, 4, 4, 8, 6, 6};
    foreach (ops[k]) read_op(ops[k], qm[k], lat[k]);
    $display("test defaults done");
  endtask
  task automatic test_explicit;
    nv_read_param = 8'h78;
    nv_load = 1'b1;
    param_wr_data = 8'h08;
    param_wr = 1'b1;
    cyc(1);
    param_wr = 1'b0;
    nv_load = 1'b0;
    chk("param", read_param_reg, 8'h08);
    read_op(8'h0b, 1'b1, 8'h01);
    nv_load = 1'b1;
    cyc(1);
    nv_load = 1'b0;
    chk("param", read_param_reg, 8'h78);
    read_op(8'heb, 1'b0, 8'h0f);
    $display("test explicit done");
  endtask
  task automatic test_reject;
    param_wr_data = 8'h7f;
    param_wr = 1'b1;
    cyc(1);
    param_wr = 1'b0;
    qmode = 1'b1;
    sel = 1'b1;
    cyc(3);
    cmd_opcode = 8'hbe;
    cmd_valid = 1'b1;
    cyc(1);
    cmd_valid = 1'b0;
    chk("reject", {7'h0, cmd_reject_reg}, 8'h01);
    cyc(1);
    chk("dummy", {7'h0, dummy_phase}, 8'h00);
    sel = 1'b0;
    cyc(6);
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(1);
    chk("param", read_param_reg, 8'h00);
    chk("latency", {4'h0, latency_reg}, 8'h00);
    $display("test reject done");
  endtask
  initial begin
    srst = 1'b1;
    {sel, run, qmode, cmd_valid, addr_done, nv_load, param_wr} = '0;
    {cmd_opcode, nv_read_param, param_wr_data} = '0;
    cyc(12);
    srst = 1'b0;
    cyc(1);
    chk("param", read_param_reg, 8'h00);
    chk("latency", {4'h0, latency_reg}, 8'h00);
    test_defaults();
    test_explicit();
    test_reject();
    end_sim();
  end
endmodule
